//--- hdl/mcu_core_instruction_exec.v
// Function
// - add, and, compare, subtract: accumulator with memory or immediate, 4 cycles, Z and C
// - increment, decrement, clear reach all 256 data bytes; inc/dec change only Z
// - complement, rotate through carry, shift left act on accumulator, set Z and C
// - relative branches on C, NC, Z, NZ take 2 cycles, flags kept
// - relative branch uses 5-bit signed offset, target -15 to +16 around it
// - bit-test branches take 5 cycles, branch on bit clear/set, bit into C
// - bit-test branch third byte is 8-bit offset, range -126 to +129
// - bit set/clear any data bit, 3-bit select, two bytes, 4 cycles, flags kept
// - jump and call use 12-bit target, two bytes, 4 cycles, flags kept
// - with watchdog selected, stop behaves as wait
// - nop, return, interrupt return, stop, wait: one byte, 2 cycles
// - return addresses live in a six-cell 12-bit stack
// - indirect operations pick pointer 80h or 81h by opcode bit 4
`timescale 1ns/1ps
`include "mcu_core_defs.vh"
module mcu_core_instruction_exec (
  input wire CLK,
  input wire RST,
  output wire [11:0] PADDR,
  input wire [7:0] PRD,
  output wire [7:0] DADDR,
  input wire [7:0] DRD,
  output wire DRE,
  output wire [7:0] DWD,
  output wire DWE,
  input wire IRQ,
  input wire [11:0] IRQ_VEC,
  input wire WDOG_SEL,
  output wire WAITING,
  output wire STOPPED,
  output wire IN_INT,
  output wire ZERO,
  output wire CARRY,
  output wire [7:0] ACC
);
  localparam ST_RUN = 2'b01;
  localparam ST_SLEEP = 2'b10;

  reg [1:0] state_r;
  reg [2:0] cyc_r;
  reg [11:0] pc_r;
  reg [11:0] opaddr_r;
  reg [7:0] op_r;
  reg [7:0] b2_r;
  reg [7:0] daddr_r;
  reg [7:0] acc_r;
  reg z_r;
  reg c_r;
  reg zs_r;
  reg cs_r;
  reg intm_r;
  reg stop_r;
  reg tbit_r;
  reg [7:0] dwd_r;
  reg dwe_r;

  wire [11:0] stack_top;
  wire run = (state_r == ST_RUN);
  wire [1:0] grp = op_r[`OP_GRP_HI:`OP_GRP_LO];
  wire is_rel = ~op_r[`OP_BIT0];
  wire is_jc = op_r[`OP_BIT0] & (grp == `GRP_JUMP);
  wire is_bt = op_r[`OP_BIT0] & (grp == `GRP_BIT) & ~op_r[`OP_FORM];
  wire is_bs = op_r[`OP_BIT0] & (grp == `GRP_BIT) & op_r[`OP_FORM];
  wire is_inh = op_r[`OP_BIT0] & (grp == `GRP_INH);
  wire is_alu = op_r[`OP_BIT0] & (grp == `GRP_ALU);
  wire is_ind = is_alu & ~op_r[`OP_FORM];
  wire is_imm = is_alu & op_r[`OP_FORM] & ~op_r[`OP_SEL];
  wire [2:0] aop = op_r[`OP_HI_MSB:`OP_HI_LSB];
  wire [3:0] iop = op_r[`OP_HI_MSB:`OP_SEL];
  wire two_byte = is_jc | is_bs | is_bt | (is_alu & op_r[`OP_FORM]);
  wire [2:0] len = (is_rel | is_inh) ? `CYC_SHORT : (is_bt ? `CYC_BITTEST : `CYC_LONG);
  wire last = (cyc_r == len - 3'h1);
  wire irq_take = run & (cyc_r == 3'h0) & IRQ & ~intm_r;

  // operand of the data phase; the accumulator answers for its own data address
  wire acc_sel = (daddr_r == `ACC_ADDR);
  wire [7:0] opv = is_imm ? b2_r : (acc_sel ? acc_r : DRD);
  wire [8:0] sum = {1'b0, acc_r} + {1'b0, opv};
  wire [8:0] diff = {1'b0, acc_r} - {1'b0, opv};
  wire [7:0] mask = 8'h01 << aop;
  wire bitv = opv[aop];

  reg [7:0] res;
  reg res_c;
  reg to_acc;
  reg to_mem;
  reg upd_z;
  reg upd_c;
  always @* begin
    res = 8'h00;
    res_c = c_r;
    to_acc = 1'b0;
    to_mem = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    if (is_bs) begin
      res = op_r[`OP_SEL] ? (opv | mask) : (opv & ~mask);
      to_mem = 1'b1;
    end else if (is_alu) begin
      case (aop)
        `ALU_ADD: begin
          res = sum[7:0];
          res_c = sum[8];
          to_acc = 1'b1;
          upd_z = 1'b1;
          upd_c = 1'b1;
        end
        `ALU_AND: begin
          res = acc_r & opv;
          res_c = 1'b0;
          to_acc = 1'b1;
          upd_z = 1'b1;
          upd_c = 1'b1;
        end
        `ALU_CP, `ALU_SUB: begin
          res = diff[7:0];
          res_c = diff[8];
          to_acc = (aop == `ALU_SUB);
          upd_z = 1'b1;
          upd_c = 1'b1;
        end
        `ALU_INC, `ALU_DEC: begin
          res = (aop == `ALU_INC) ? opv + 8'h01 : opv - 8'h01;
          to_mem = ~is_imm;
          upd_z = ~is_imm;
        end
        `ALU_CLR: begin
          res = 8'h00;
          res_c = 1'b0;
          to_mem = ~is_imm;
          upd_z = ~is_imm & acc_sel;
          upd_c = ~is_imm & acc_sel;
        end
        default: begin
          res = 8'h00;
        end
      endcase
    end
  end

  // inherent accumulator operations; each one moves the old top bit into carry
  wire [7:0] ires = (iop == `INH_COM) ? ~acc_r : {acc_r[6:0], (iop == `INH_RLC) & c_r};
  wire ires_c = acc_r[7];
  wire cond = (grp == `CND_NZ) ? ~z_r : (grp == `CND_NC) ? ~c_r : (grp == `CND_Z) ? z_r : c_r;
  wire is_ret = is_inh & ((iop == `INH_RET) | (iop == `INH_RETURN_FROM_INTERRUPT));
  wire st_push = irq_take | (run & last & is_jc & ~op_r[`OP_FORM]);
  wire st_pop = run & last & is_ret;
  wire [11:0] rel_tgt = opaddr_r + 12'h001 + {{7{op_r[7]}}, op_r[7:3]};
  wire [11:0] bt_tgt = opaddr_r + 12'h002 + {{4{b2_r[7]}}, b2_r};

  return_stack u_stack (
    .clk(CLK),
    .rst(RST),
    .push(st_push),
    .pop(st_pop),
    .din(pc_r),
    .dout(stack_top)
  );

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= ST_RUN;
      cyc_r <= 3'h0;
      pc_r <= `RESET_PC;
      opaddr_r <= `RESET_PC;
      op_r <= 8'h00;
      b2_r <= 8'h00;
      daddr_r <= 8'h00;
      acc_r <= 8'h00;
      z_r <= 1'b0;
      c_r <= 1'b0;
      zs_r <= 1'b0;
      cs_r <= 1'b0;
      intm_r <= 1'b0;
      stop_r <= 1'b0;
      tbit_r <= 1'b0;
      dwd_r <= 8'h00;
      dwe_r <= 1'b0;
    end else begin
      dwe_r <= 1'b0;
      case (state_r)
        ST_RUN: begin
          cyc_r <= cyc_r + 3'h1;
          if (cyc_r == 3'h0) begin
            if (irq_take) begin
              // interrupt entry costs one cycle and saves the flags for the return
              cyc_r <= 3'h0;
              pc_r <= IRQ_VEC;
              zs_r <= z_r;
              cs_r <= c_r;
              intm_r <= 1'b1;
            end else begin
              op_r <= PRD;
              opaddr_r <= pc_r;
              pc_r <= pc_r + 12'h001;
              daddr_r <= `PTR_X_ADDR | {7'h00, PRD[`OP_SEL]};
            end
          end else if (last) begin
            cyc_r <= 3'h0;
            if (is_rel & cond) begin
              pc_r <= rel_tgt;
            end
            if (is_jc) begin
              pc_r <= {op_r[7:4], b2_r};
            end
            if (is_bt) begin
              c_r <= tbit_r;
              if (tbit_r == op_r[`OP_SEL]) begin
                pc_r <= bt_tgt;
              end
            end
            if (is_inh) begin
              case (iop)
                `INH_RET: pc_r <= stack_top;
                `INH_RETURN_FROM_INTERRUPT: begin
                  pc_r <= stack_top;
                  z_r <= zs_r;
                  c_r <= cs_r;
                  intm_r <= 1'b0;
                end
                `INH_STOP, `INH_WAIT: begin
                  state_r <= ST_SLEEP;
                  stop_r <= (iop == `INH_STOP) & ~WDOG_SEL;
                end
                `INH_COM, `INH_RLC, `INH_SLA: begin
                  acc_r <= ires;
                  z_r <= (ires == 8'h00);
                  c_r <= ires_c;
                end
                default: begin
                  acc_r <= acc_r;
                end
              endcase
            end
          end else if (cyc_r == 3'h1) begin
            if (two_byte) begin
              b2_r <= PRD;
              pc_r <= pc_r + 12'h001;
            end
            daddr_r <= is_ind ? DRD : PRD;
          end else if (cyc_r == 3'h2) begin
            if (is_bt) begin
              // third byte replaces the consumed address byte as the offset
              tbit_r <= bitv;
              b2_r <= PRD;
              pc_r <= pc_r + 12'h001;
            end
            if (to_acc | (to_mem & acc_sel)) begin
              acc_r <= res;
            end else if (to_mem) begin
              dwd_r <= res;
              dwe_r <= 1'b1;
            end
            if (upd_z) begin
              z_r <= (res == 8'h00);
            end
            if (upd_c) begin
              c_r <= res_c;
            end
          end
        end
        ST_SLEEP: begin
          // only an interrupt request wakes the core; the fetch then takes it unless IN_INT is already set
          if (IRQ) begin
            state_r <= ST_RUN;
            stop_r <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  assign PADDR = pc_r;
  assign DADDR = daddr_r;
  assign DRE = run & (((cyc_r == 3'h1) & is_ind) |
               ((cyc_r == 3'h2) & ((is_alu & ~is_imm) | is_bt | is_bs)));
  assign DWD = dwd_r;
  assign DWE = dwe_r;
  assign WAITING = (state_r == ST_SLEEP) & ~stop_r;
  assign STOPPED = (state_r == ST_SLEEP) & stop_r;
  assign IN_INT = intm_r;
  assign ZERO = z_r;
  assign CARRY = c_r;
  assign ACC = acc_r;
endmodule // mcu_core_instruction_exec

//--- hdl/mcu_core_defs.vh
`ifndef MCU_CORE_DEFS_VH
`define MCU_CORE_DEFS_VH

// reset and data space landmarks
`define RESET_PC 12'h000
`define PTR_X_ADDR 8'h80
`define ACC_ADDR 8'hff

// instruction lengths in clock cycles
`define CYC_SHORT 3'h2
`define CYC_LONG 3'h4
`define CYC_BITTEST 3'h5

// return stack
`define STACK_DEPTH 6
`define PC_W 12

// opcode field positions
`define OP_BIT0 0
`define OP_GRP_HI 2
`define OP_GRP_LO 1
`define OP_FORM 3
`define OP_SEL 4
`define OP_HI_MSB 7
`define OP_HI_LSB 5

// groups in opcode bits 2:1 when bit 0 is set
`define GRP_JUMP 2'h0
`define GRP_BIT 2'h1
`define GRP_INH 2'h2
`define GRP_ALU 2'h3

// relative branch conditions in opcode bits 2:1 when bit 0 is clear
`define CND_NZ 2'h0
`define CND_NC 2'h1
`define CND_Z 2'h2
`define CND_C 2'h3

// alu operation in opcode bits 7:5
`define ALU_ADD 3'h0
`define ALU_AND 3'h1
`define ALU_CP 3'h2
`define ALU_SUB 3'h3
`define ALU_INC 3'h4
`define ALU_DEC 3'h5
`define ALU_CLR 3'h6

// inherent operation in opcode bits 7:4
`define INH_NOP 4'h0
`define INH_RET 4'h1
`define INH_RETURN_FROM_INTERRUPT 4'h2
`define INH_STOP 4'h3
`define INH_WAIT 4'h4
`define INH_COM 4'h5
`define INH_RLC 4'h6
`define INH_SLA 4'h7

`endif

//--- hdl/return_stack.v
`timescale 1ns/1ps
`include "mcu_core_defs.vh"
module return_stack (
  input wire clk,
  input wire rst,
  input wire push,
  input wire pop,
  input wire [`PC_W-1:0] din,
  output wire [`PC_W-1:0] dout
);
  // a shift stack: a seventh push loses the oldest address, nesting is limited to six
  reg [`PC_W-1:0] cell_r [0:`STACK_DEPTH-1];
  genvar i;
  generate
    for (i = 0; i < `STACK_DEPTH; i = i + 1) begin : g_cell
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          cell_r[i] <= {`PC_W{1'b0}};
        end else if (push) begin
          cell_r[i] <= (i == 0) ? din : cell_r[(i == 0) ? 0 : i - 1];
        end else if (pop) begin
          cell_r[i] <= (i == `STACK_DEPTH - 1) ? {`PC_W{1'b0}} :
                       cell_r[(i == `STACK_DEPTH - 1) ? i : i + 1];
        end
      end
    end
  endgenerate
  assign dout = cell_r[0];
endmodule // return_stack

//--- tb/mcu_mem_model.sv
`timescale 1ns/1ps
module mcu_mem (
  input wire clk,
  input wire [11:0] paddr,
  output wire [7:0] prd,
  input wire [7:0] daddr,
  input wire dre,
  output wire [7:0] drd,
  input wire [7:0] dwd,
  input wire dwe
);
  reg [7:0] pmem [0:4095];
  reg [7:0] dmem [0:255];
  assign prd = pmem[paddr];
  // bus shows the inverse outside a strobe, so a stray read never matches
  assign drd = dre ? dmem[daddr] : ~dmem[daddr];
  always @(posedge clk) begin
    if (dwe) begin
      dmem[daddr] <= dwd;
    end
  end
endmodule // mcu_mem

//--- tb/mcu_core_exec_properties.sv
`timescale 1ns/1ps
module mcu_core_exec_properties (
  input wire CLK,
  input wire RST,
  input wire IRQ,
  input wire [11:0] PADDR,
  input wire [7:0] PRD,
  input wire [7:0] DRD,
  input wire DWE,
  input wire WDOG_SEL,
  input wire WAITING,
  input wire STOPPED,
  input wire IN_INT,
  input wire ZERO,
  input wire CARRY,
  input wire [7:0] ACC
);
  // shadow of the instruction in flight; it holds still for the extra interrupt entry cycle
  reg [2:0] cyc_r;
  reg vld_r, bit_r;
  reg [7:0] op_r, b2_r, b3_r, acc_r;
  reg [11:0] pc_r;
  reg [1:0] zc_r;
  wire awake = !WAITING && !STOPPED;
  wire nxt = vld_r && awake && cyc_r == 3'h0;
  wire take = awake && cyc_r == 3'h0 && IRQ && !IN_INT;
  wire [2:0] last = (!op_r[0] || op_r[2:0] == 3'h5) ? 3'h1 : (op_r[3:0] == 4'h3) ? 3'h4 : 3'h3;
  wire rtk = (op_r[1] ? CARRY : ZERO) == op_r[2];
  wire btk = bit_r == op_r[4];
  default clocking @(posedge CLK); endclocking
  default disable iff (RST || IN_INT);
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      cyc_r <= 3'h0;
      vld_r <= 1'b0;
      op_r <= 8'h00;
    end else if (awake && !take) begin
      if (cyc_r == 3'h0) begin
        op_r <= PRD;
        pc_r <= PADDR;
        acc_r <= ACC;
        zc_r <= {ZERO, CARRY};
        vld_r <= 1'b1;
      end
      if (cyc_r == 3'h1) begin
        b2_r <= PRD;
      end
      if (cyc_r == 3'h2) begin
        b3_r <= PRD;
        bit_r <= DRD[op_r[7:5]];
      end
      cyc_r <= (cyc_r == last) ? 3'h0 : cyc_r + 3'h1;
    end
  end
  a_rel_target: assert property (nxt && !op_r[0] |->
    PADDR == pc_r + 12'h1 + (rtk ? {{7{op_r[7]}}, op_r[7:3]} : 12'h0))
    else $error("relative branch target wrong");
  a_flags_kept: assert property (nxt && (!op_r[0] || op_r[2:0] == 3'h1 ||
    op_r[3:0] == 4'hb || op_r[3:0] == 4'h5 && op_r[7:4] < 4'h5 && op_r[7:4] != 4'h2)
    |-> {ZERO, CARRY} == zc_r) else $error("flags changed");
  a_long_target: assert property (nxt && op_r[2:0] == 3'h1 |->
    PADDR == {op_r[7:4], b2_r}) else $error("long target wrong");
  a_bit_carry: assert property (nxt && op_r[3:0] == 4'h3 |->
    CARRY == bit_r && ZERO == zc_r[1]) else $error("tested bit not in carry");
  a_bit_target: assert property (nxt && op_r[3:0] == 4'h3 |->
    PADDR == pc_r + (btk ? 12'h2 + {{4{b3_r[7]}}, b3_r} : 12'h3))
    else $error("bit test target wrong");
  a_add_imm: assert property (nxt && op_r == 8'h0f |->
    {CARRY, ACC} == {1'b0, acc_r} + {1'b0, b2_r} && ZERO == (ACC == 8'h00))
    else $error("add result wrong");
  a_incdec_carry: assert property (nxt && op_r[2:0] == 3'h7 && op_r[7:6] == 2'h2 |->
    CARRY == zc_r[0]) else $error("carry moved");
  a_stop_wdog: assert property ($rose(STOPPED) |-> !$past(WDOG_SEL))
    else $error("stop entered with watchdog");
  a_write_slot: assert property (DWE |-> cyc_r == 3'h3 ##1 !DWE)
    else $error("write strobe misplaced");
  c_rel: cover property (nxt && !op_r[0] && rtk);
  c_bit: cover property (nxt && op_r[3:0] == 4'h3 && btk);
  c_call: cover property (nxt && op_r[3:0] == 4'h1);
  c_return_from_interrupt: cover property ($fell(IN_INT));
endmodule // mcu_core_exec_properties
bind mcu_core_instruction_exec mcu_core_exec_properties props (.CLK(CLK), .RST(RST), .IRQ(IRQ),
  .PADDR(PADDR), .PRD(PRD), .DRD(DRD), .DWE(DWE), .WDOG_SEL(WDOG_SEL), .WAITING(WAITING),
  .STOPPED(STOPPED), .IN_INT(IN_INT), .ZERO(ZERO), .CARRY(CARRY), .ACC(ACC));

//--- tb/mcu_core_instruction_exec_tb.sv
`timescale 1ns/1ps
module mcu_core_instruction_exec_tb;
  reg CLK, RST, IRQ, WDOG_SEL;
  reg [11:0] IRQ_VEC;
  wire [11:0] PADDR;
  wire [7:0] PRD, DADDR, DRD, DWD, ACC;
  wire DRE, DWE, WAITING, STOPPED, IN_INT, ZERO, CARRY;
  wire [11:0] zca = {2'h0, ZERO, CARRY, ACC};
  integer err_count, checked;
  integer ticks = 0;
  mcu_core_instruction_exec dut (.CLK(CLK), .RST(RST), .PADDR(PADDR), .PRD(PRD),
    .DADDR(DADDR), .DRD(DRD), .DRE(DRE), .DWD(DWD), .DWE(DWE), .IRQ(IRQ),
    .IRQ_VEC(IRQ_VEC), .WDOG_SEL(WDOG_SEL), .WAITING(WAITING), .STOPPED(STOPPED),
    .IN_INT(IN_INT), .ZERO(ZERO), .CARRY(CARRY), .ACC(ACC));
  mcu_mem mem (.clk(CLK), .paddr(PADDR), .prd(PRD), .daddr(DADDR), .dre(DRE),
    .drd(DRD), .dwd(DWD), .dwe(DWE));
  always #2.5 CLK = ~CLK;
  task give_verdict;
    begin
      if (err_count == 0 && checked > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  // hang guard: all scenarios together need under 160 cycles
  always @(posedge CLK) begin
    ticks <= ticks + 1;
    if (ticks == 1000) begin
      err_count = err_count + 1;
      give_verdict;
    end
  end
  task chk(input [11:0] seen, input [11:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task run(input integer n);
    repeat (n) @(negedge CLK);
  endtask
  task hold;
    integer i;
    begin
      RST = 1'b1;
      for (i = 0; i < 4096; i = i + 1) begin
        mem.pmem[i] = 8'h00;
        mem.dmem[i % 256] = 8'h00;
      end
      run(10);
    end
  endtask
  task put(input [11:0] a, input [31:0] w);
    begin
      mem.pmem[a] = w[31:24];
      mem.pmem[a + 12'h1] = w[23:16];
      mem.pmem[a + 12'h2] = w[15:8];
      mem.pmem[a + 12'h3] = w[7:0];
    end
  endtask
  task s_branch;
    begin
      hold;
      WDOG_SEL = 1'b0;
      put(12'h000, 32'h0f800f80);
      put(12'h004, 32'h282a7c00);
      put(12'h008, 32'h35000000);
      put(12'h016, 32'h8e000000);
      RST = 1'b0;
      run(8);
      chk(zca, 12'h300);
      run(2);
      chk(PADDR, 12'h005);
      run(2);
      chk(PADDR, 12'h006);
      run(2);
      chk(PADDR, 12'h016);
      run(2);
      chk(PADDR, 12'h008);
      chk(zca, 12'h300);
      run(4);
      chk({11'h0, STOPPED}, 12'h001);
    end
  endtask
  task s_call;
    begin
      hold;
      WDOG_SEL = 1'b1;
      put(12'h000, 32'h1123a9bc);
      put(12'h123, 32'h15000000);
      put(12'habc, 32'h35000000);
      RST = 1'b0;
      run(4);
      chk(PADDR, 12'h123);
      run(2);
      chk(PADDR, 12'h002);
      run(4);
      chk(PADDR, 12'habc);
      run(4);
      chk({10'h0, WAITING, STOPPED}, 12'h002);
    end
  endtask
  task s_mem;
    begin
      hold;
      WDOG_SEL = 1'b0;
      mem.dmem[8'h40] = 8'h01;
      mem.dmem[8'h41] = 8'h01;
      mem.dmem[8'h80] = 8'h40;
      put(12'h000, 32'h9f40bf41);
      put(12'h004, 32'hfb40f340);
      put(12'h008, 32'h7f000000);
      put(12'h087, 32'h67eb402f);
      put(12'h08b, 32'h0f4f0edf);
      put(12'h08f, 32'h40000000);
      RST = 1'b0;
      run(17);
      chk(PADDR, 12'h087);
      chk(zca, 12'h300);
      chk({4'h0, mem.dmem[8'h41]}, 12'h000);
      run(4);
      chk(zca, 12'h17e);
      run(4);
      chk({4'h0, mem.dmem[8'h40]}, 12'h002);
      run(12);
      chk(PADDR, 12'h090);
      chk(zca, 12'h20e);
      chk({4'h0, mem.dmem[8'h40]}, 12'h000);
    end
  endtask
  task s_acc;
    begin
      hold;
      put(12'h000, 32'h0f815565);
      put(12'h004, 32'h75000000);
      RST = 1'b0;
      run(10);
      chk(PADDR, 12'h005);
      chk(zca, 12'h1fa);
    end
  endtask
  task s_irq;
    begin
      hold;
      mem.dmem[8'h81] = 8'h30;
      mem.dmem[8'h30] = 8'h01;
      put(12'h000, 32'h0f004517);
      put(12'h004, 32'h23301000);
      put(12'h016, 32'h05000000);
      put(12'h200, 32'h0fff2500);
      RST = 1'b0;
      run(8);
      chk({WAITING, IN_INT, ZERO, CARRY, ACC}, 12'ha00);
      IRQ_VEC = 12'h200;
      IRQ = 1'b1;
      run(2);
      chk(PADDR, 12'h200);
      chk({WAITING, IN_INT, ZERO, CARRY, ACC}, 12'h600);
      IRQ = 1'b0;
      run(4);
      chk({WAITING, IN_INT, ZERO, CARRY, ACC}, 12'h4ff);
      run(2);
      chk(PADDR, 12'h003);
      chk({WAITING, IN_INT, ZERO, CARRY, ACC}, 12'h2ff);
      run(4);
      chk(PADDR, 12'h004);
      chk(zca, 12'h300);
      run(5);
      chk(PADDR, 12'h016);
      chk(zca, 12'h200);
      run(2);
      chk(PADDR, 12'h017);
      chk(zca, 12'h200);
    end
  endtask
  initial begin
    CLK = 1'b0;
    RST = 1'b1;
    IRQ = 1'b0;
    IRQ_VEC = 12'h000;
    WDOG_SEL = 1'b0;
    err_count = 0;
    checked = 0;
    s_branch;
    s_call;
    s_mem;
    s_acc;
    s_irq;
    give_verdict;
  end
endmodule // mcu_core_instruction_exec_tb
